// [hdl/hdlct_top.v]
// hdlc transmit framer with byte queue behind an axi4-lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "hdlct_defines.vh"
module hdlct_top #(
    parameter AW = 7,
    parameter DEPTH = 128
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // link
    input wire bit_tick,
    output reg line_bit_q,
    output reg overflow_output,
    output reg irq_out_n
);
    reg [7:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0] eom_q;
    reg [AW-1:0] wr_q, rd_q;
    reg [AW:0] cnt_q, pkt_q;
    reg [7:0] aw_a_q, w_d_q, sh_q;
    reg aw_f_q, w_f_q, w_s_q;
    reg en_q, crc_en_q, qclr_q;
    reg [6:0] upper_q, lower_q;
    reg [3:0] ien_q, ev_q;
    reg ur_hold_q, ov_hold_q, abort_req_q, cur_eom_q, full_p_q, blow_p_q;
    reg [2:0] kind_q, bit_q, ones_q;
    reg [15:0] crc_q, fcs_q;
    reg [31:0] rd_d;
    reg [1:0] rresp_d;
    reg [2:0] kind_d;
    reg [7:0] sh_d;
    reg pop, uflow;

    wire full = (cnt_q == DEPTH);
    wire empty = (cnt_q == {(AW+1){1'b0}});
    wire blow = (cnt_q < {{(AW-6){1'b0}}, lower_q});
    wire wr_go = aw_f_q & w_f_q & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire wr_cfg = wr_go & w_s_q & (aw_a_q == `HT_A_CFG);
    wire wr_data = wr_go & w_s_q & (aw_a_q == `HT_A_DATA);
    wire in_flight = (kind_q == `HT_K_DATA) & (pkt_q == {(AW+1){1'b0}});
    wire push = wr_data & ~full & ~ur_hold_q;
    wire ovf = wr_data & full & ~ur_hold_q;
    wire ovf_cur = ovf & in_flight;
    wire mark = wr_cfg & w_d_q[`HT_B_EOM] & ~empty & ~ur_hold_q;
    wire flush = qclr_q | ur_hold_q | ovf_cur | (ov_hold_q & ~push);
    wire stuffed = (kind_q == `HT_K_DATA) | (kind_q == `HT_K_FCS1) | (kind_q == `HT_K_FCS2);
    // a run of five may close the fcs, so its zero still goes out before the closing flag
    wire do_stuff = bit_tick & (ones_q == `HT_STUFF_RUN);
    wire do_bit = bit_tick & ~do_stuff;
    wire byte_end = do_bit & (bit_q == `HT_LAST_BIT);
    wire go = (pkt_q != {(AW+1){1'b0}}) | (cnt_q > {{(AW-6){1'b0}}, upper_q});
    wire fb = crc_q[0] ^ sh_q[0];
    wire [15:0] crc_nx = {1'b0, crc_q[15:1]} ^ (fb ? `HT_CRC_POLY : 16'h0000);

    always @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= w_d_q;
        end
    end

    // next byte on the line, chosen at each byte boundary
    always @* begin
        kind_d = `HT_K_FLAG;
        sh_d = en_q ? `HT_FLAG : `HT_ONES;
        pop = 1'b0;
        uflow = 1'b0;
        if (abort_req_q) begin
            kind_d = `HT_K_ABORT;
            sh_d = `HT_ABORT;
        end else if (kind_q == `HT_K_DATA) begin
            if (cur_eom_q) begin
                if (crc_en_q) begin
                    kind_d = `HT_K_FCS1;
                    sh_d = ~crc_nx[7:0];
                end
            end else if (!empty && !ov_hold_q) begin
                kind_d = `HT_K_DATA;
                sh_d = mem[rd_q];
                pop = 1'b1;
            end else begin
                kind_d = `HT_K_ABORT;
                sh_d = `HT_ABORT;
                uflow = 1'b1;
            end
        end else if (kind_q == `HT_K_FCS1) begin
            kind_d = `HT_K_FCS2;
            sh_d = fcs_q[15:8];
        end else if (kind_q != `HT_K_FCS2 && en_q && go && !empty && !ov_hold_q
                     && !ur_hold_q) begin
            kind_d = `HT_K_DATA;
            sh_d = mem[rd_q];
            pop = 1'b1;
        end
    end

    // register read mux
    always @* begin
        rd_d = 32'h0000_0000;
        rresp_d = `HT_OKAY;
        case (s_axi_araddr)
            `HT_A_CFG: rd_d = {29'h0, qclr_q, crc_en_q, en_q};
            `HT_A_UPPER: rd_d = {25'h0, upper_q};
            `HT_A_LOWER: rd_d = {25'h0, lower_q};
            `HT_A_IEN: rd_d = {28'h0, ien_q};
            `HT_A_STAT: rd_d = {26'h0, blow, full, ev_q};
            `HT_A_DATA: rd_d = 32'h0000_0000;
            default: rresp_d = `HT_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HT_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `HT_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_f_q <= 1'b0;
            w_f_q <= 1'b0;
            aw_a_q <= 8'h00;
            w_d_q <= 8'h00;
            w_s_q <= 1'b0;
            en_q <= 1'b0;
            crc_en_q <= 1'b0;
            qclr_q <= 1'b0;
            upper_q <= `HT_RST_UPPER;
            lower_q <= `HT_RST_LOWER;
            ien_q <= 4'h0;
            ev_q <= 4'h0;
            full_p_q <= 1'b0;
            blow_p_q <= 1'b0;
            ur_hold_q <= 1'b0;
            ov_hold_q <= 1'b0;
            abort_req_q <= 1'b0;
            overflow_output <= 1'b0;
            irq_out_n <= 1'b1;
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            pkt_q <= {(AW+1){1'b0}};
            eom_q <= {DEPTH{1'b0}};
            kind_q <= `HT_K_FLAG;
            sh_q <= `HT_ONES;
            bit_q <= 3'h0;
            ones_q <= 3'h0;
            cur_eom_q <= 1'b0;
            crc_q <= `HT_CRC_INIT;
            fcs_q <= 16'h0000;
            line_bit_q <= 1'b1;
        end else begin
            // write channels are taken in either order, then answered
            if (s_axi_awvalid && s_axi_awready) begin
                aw_f_q <= 1'b1;
                aw_a_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_f_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_f_q <= 1'b1;
                w_d_q <= s_axi_wdata[7:0];
                w_s_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_f_q <= 1'b0;
            end
            s_axi_awready <= ~aw_f_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_f_q & ~(s_axi_wvalid & s_axi_wready);
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_a_q > `HT_A_DATA || aw_a_q[1:0] != 2'h0)
                               ? `HT_SLVERR : `HT_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_rvalid & ~rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rresp_d;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (wr_cfg) begin
                en_q <= w_d_q[`HT_B_EN];
                crc_en_q <= w_d_q[`HT_B_CRC];
                qclr_q <= w_d_q[`HT_B_QCLR];
            end
            if (wr_go && w_s_q && aw_a_q == `HT_A_UPPER) begin
                upper_q <= w_d_q[6:0];
            end
            if (wr_go && w_s_q && aw_a_q == `HT_A_LOWER) begin
                lower_q <= w_d_q[6:0];
            end
            if (wr_go && w_s_q && aw_a_q == `HT_A_IEN) begin
                ien_q <= w_d_q[3:0];
            end
            // events: a set in the same cycle as a clear wins
            full_p_q <= full;
            blow_p_q <= blow;
            ev_q[`HT_E_CAP] <= (ev_q[`HT_E_CAP] & ~(rd_go && s_axi_araddr == `HT_A_STAT))
                               | (full & ~full_p_q);
            ev_q[`HT_E_LOW] <= (ev_q[`HT_E_LOW] & ~(rd_go && s_axi_araddr == `HT_A_STAT))
                               | (blow & ~blow_p_q);
            ev_q[`HT_E_OVR] <= (ev_q[`HT_E_OVR] & ~(rd_go && s_axi_araddr == `HT_A_STAT))
                               | ovf;
            ev_q[`HT_E_UDR] <= (ev_q[`HT_E_UDR] & ~(wr_go && aw_a_q == `HT_A_STAT))
                               | (byte_end & uflow);
            irq_out_n <= ~|(ev_q & ien_q);
            // underrun hold lasts until the status register is written
            if (byte_end && uflow) begin
                ur_hold_q <= 1'b1;
            end else if (wr_go && aw_a_q == `HT_A_STAT) begin
                ur_hold_q <= 1'b0;
            end
            if (ovf) begin
                overflow_output <= 1'b1;
            end else if (wr_data) begin
                overflow_output <= 1'b0;
            end
            if (ovf_cur) begin
                ov_hold_q <= 1'b1;
            end else if (push) begin
                ov_hold_q <= 1'b0;
            end
            if (ovf_cur) begin
                abort_req_q <= 1'b1;
            end else if (byte_end) begin
                abort_req_q <= 1'b0;
            end
            // queue pointers; a full-queue write is dropped, spoiling only its packet
            if (flush) begin
                wr_q <= {AW{1'b0}};
                rd_q <= {AW{1'b0}};
                cnt_q <= {(AW+1){1'b0}};
                pkt_q <= {(AW+1){1'b0}};
                eom_q <= {DEPTH{1'b0}};
            end else begin
                if (push) begin
                    wr_q <= wr_q + 1'b1;
                    eom_q[wr_q] <= 1'b0;
                end
                if (mark) begin
                    eom_q[wr_q - 1'b1] <= 1'b1;
                end
                if (byte_end && pop) begin
                    rd_q <= rd_q + 1'b1;
                end
                cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, byte_end & pop};
                pkt_q <= pkt_q + {{AW{1'b0}}, mark}
                         - {{AW{1'b0}}, byte_end & pop & eom_q[rd_q]};
            end
            // serialiser, lsb first; flags and aborts bypass zero insertion
            if (do_stuff) begin
                line_bit_q <= 1'b0;
                ones_q <= 3'h0;
            end else if (do_bit) begin
                line_bit_q <= sh_q[0];
                ones_q <= (stuffed && sh_q[0]) ? ones_q + 3'h1 : 3'h0;
                sh_q <= {1'b0, sh_q[7:1]};
                bit_q <= bit_q + 3'h1;
                if (kind_q == `HT_K_DATA) begin
                    crc_q <= crc_nx;
                end
            end
            if (byte_end) begin
                kind_q <= kind_d;
                sh_q <= sh_d;
                if (pop) begin
                    cur_eom_q <= eom_q[rd_q];
                end
                if (kind_q != `HT_K_DATA) begin
                    crc_q <= `HT_CRC_INIT;
                end
                if (kind_d == `HT_K_FCS1) begin
                    fcs_q <= ~crc_nx;
                end
            end
        end
    end
endmodule // hdlct_top

// [inc/hdlct_defines.vh]
// register map, field positions and line constants of the hdlc transmitter
`ifndef HDLCT_DEFINES_VH
`define HDLCT_DEFINES_VH
`define HT_A_CFG 8'h00
`define HT_A_UPPER 8'h04
`define HT_A_LOWER 8'h08
`define HT_A_IEN 8'h0C
`define HT_A_STAT 8'h10
`define HT_A_DATA 8'h14
`define HT_B_EN 0
`define HT_B_CRC 1
`define HT_B_QCLR 2
`define HT_B_EOM 3
`define HT_E_CAP 0
`define HT_E_LOW 1
`define HT_E_OVR 2
`define HT_E_UDR 3
`define HT_S_FULL 4
`define HT_S_BLOW 5
`define HT_RST_UPPER 7'h40
`define HT_RST_LOWER 7'h10
`define HT_FLAG 8'h7E
`define HT_ABORT 8'hFF
`define HT_ONES 8'hFF
`define HT_CRC_INIT 16'hFFFF
`define HT_CRC_POLY 16'h8408
`define HT_STUFF_RUN 3'h5
`define HT_LAST_BIT 3'h7
`define HT_OKAY 2'h0
`define HT_SLVERR 2'h2
`define HT_K_FLAG 3'h0
`define HT_K_DATA 3'h1
`define HT_K_FCS1 3'h2
`define HT_K_FCS2 3'h3
`define HT_K_ABORT 3'h4
`endif

// [testbench/hdlct_chk_sva.sv]
// port checker for the hdlc transmitter
`timescale 1ns/1ps
module hdlct_chk #(
    parameter AW = 7,
    parameter DEPTH = 128
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // link
    input wire bit_tick,
    input wire line_bit_q,
    input wire overflow_output,
    input wire irq_out_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_vals: assert property (disable iff (1'b0) !aresetn |=> irq_out_n && line_bit_q
        && !overflow_output && !s_axi_bvalid && !s_axi_rvalid) else $error("reset values");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("late write answer");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    chk_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("aw open");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    // a bit may only move on a tick, or the line rate would drift
    chk_line_hold: assert property (!bit_tick |=> $stable(line_bit_q))
        else $error("line moved without tick");
    chk_ovr_hold: assert property (overflow_output && s_axi_wready && !s_axi_wvalid
        && !s_axi_bvalid |=> overflow_output) else $error("overflow dropped");
    cover property ($rose(overflow_output));
    cover property (!irq_out_n);
    cover property (s_axi_awvalid && s_axi_awready);
endmodule // hdlct_chk
bind hdlct_top hdlct_chk #(.AW(AW), .DEPTH(DEPTH)) u_chk (.*);

// [testbench/hdlct_host.sv]
// host model: axi4-lite master that writes packet bytes and registers
`timescale 1ns/1ps
module hdlct_host (
    // clock
    input wire aclk,
    // write channels
    output reg [7:0] s_axi_awaddr,
    output reg s_axi_awvalid,
    input wire s_axi_awready,
    output reg [31:0] s_axi_wdata,
    output reg s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output reg s_axi_bready,
    // read channels
    output reg [7:0] s_axi_araddr,
    output reg s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    output reg s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    end
    // no frame_pulse_kind select sits behind these registers, so alignment order is moot
    // one access at a time, paced by the clock; one byte per data write
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        reg pa, pw, pb;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            {pa, pw, pb} = 3'h7;
            while (pb) begin
                @(posedge aclk);
                if (pa && s_axi_awready) begin
                    pa = 0;
                    s_axi_awvalid <= 0;
                end
                if (pw && s_axi_wready) begin
                    pw = 0;
                    s_axi_wvalid <= 0;
                end
                if (s_axi_bvalid) begin
                    pb = 0;
                    s_axi_bready <= 0;
                    r = s_axi_bresp;
                end
            end
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        reg pa, pr;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            {pa, pr} = 2'h3;
            while (pr) begin
                @(posedge aclk);
                if (pa && s_axi_arready) begin
                    pa = 0;
                    s_axi_arvalid <= 0;
                end
                if (s_axi_rvalid) begin
                    pr = 0;
                    s_axi_rready <= 0;
                    d = s_axi_rdata;
                end
            end
        end
    endtask
endmodule // hdlct_host

// [testbench/test_hdlct_top.sv]
// self-checking bench for the hdlc transmitter
`timescale 1ns/1ps
`include "hdlct_defines.vh"
module test_hdlct_top;
    reg aclk, aresetn, bit_tick, dat5, abt, flg;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb = 4'hF;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire line_bit_q, overflow_output, irq_out_n;
    integer failures, compares, run, i, nb;
    reg [55:0] sr;
    reg [39:0] frm;
    reg [31:0] v;
    reg [1:0] r;
    hdlct_top dut (.*);
    hdlct_host host (.*);
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    // tick every second cycle so the line must hold between ticks
    always @(posedge aclk) bit_tick <= ~bit_tick;
    // line watcher: zero after 5 ones is a stuffed bit, after 6 a flag; keeps a 5-byte frame
    always @(posedge aclk) if (!bit_tick) begin
        if (line_bit_q) begin
            run <= run + 1;
            sr <= {1'b1, sr[55:1]};
            nb <= nb + 1;
        end else begin
            if (run == 5) dat5 <= 1;
            else if (run == 6) begin
                flg <= 1;
                nb <= 0;
                if (nb == 47) frm <= sr[48:9];
            end else begin
                sr <= {1'b0, sr[55:1]};
                nb <= nb + 1;
            end
            run <= 0;
        end
        if (run >= 7) abt <= 1;
    end
    // reflected crc-16 over three bytes, lsb first, complemented
    function [15:0] fcs_of(input [23:0] d);
        integer k;
        reg [15:0] c;
        begin
            c = `HT_CRC_INIT;
            for (k = 0; k < 24; k = k + 1) begin
                c = {1'b0, c[15:1]} ^ ((c[0] ^ d[k]) ? `HT_CRC_POLY : 16'h0000);
            end
            fcs_of = ~c;
        end
    endfunction
    task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] nm);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                $display("wrong value %0s expected %h seen %h", nm, exp, seen);
                failures = failures + 1;
            end
        end
    endtask
    task test_done;
        begin
            if (failures == 0 && compares > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task wt(input integer n);
        for (i = 0; i < n; i = i + 1) @(posedge aclk);
    endtask
    task clr;
        {dat5, abt, flg} <= 3'h0;
    endtask
    task t_reset;
        begin
            host.rd(`HT_A_CFG, v);
            check(v, 0, "cfg");
            check({irq_out_n, overflow_output, line_bit_q}, 3'h5, "pins");
            host.wr(8'h1C, 0, r);
            check(r, `HT_SLVERR, "bresp");
            host.rd(`HT_A_DATA, v);
            check(v, 0, "data rd");
            check(s_axi_rresp, `HT_OKAY, "rresp");
            host.rd(8'h1C, v);
            check(s_axi_rresp, `HT_SLVERR, "rd err");
        end
    endtask
    task t_idle;
        begin
            host.wr(`HT_A_CFG, 1, r);
            host.wr(`HT_A_CFG, 5, r);
            host.wr(`HT_A_CFG, 1, r);
            wt(40);
            clr;
            wt(100);
            check({flg, abt, dat5}, 3'h4, "idle");
        end
    endtask
    task t_packet;
        begin
            host.wr(`HT_A_CFG, 3, r);
            repeat (3) host.wr(`HT_A_DATA, 8'hFF, r);
            host.wr(`HT_A_CFG, 8'hB, r);
            for (i = 0; i < 300 && !dat5; i = i + 1) @(posedge aclk);
            check(dat5, 1, "stuffed");
            wt(150);
            clr;
            wt(100);
            check({flg, abt, dat5}, 3'h4, "after");
            check(frm[23:0], 24'hFFFFFF, "payload");
            check(frm[39:24], fcs_of(24'hFFFFFF), "fcs");
        end
    endtask
    task t_underrun;
        begin
            host.wr(`HT_A_UPPER, 2, r);
            host.wr(`HT_A_IEN, 8, r);
            clr;
            repeat (4) host.wr(`HT_A_DATA, 8'hAA, r);
            for (i = 0; i < 600 && !abt; i = i + 1) @(posedge aclk);
            check(abt, 1, "abort");
            wt(4);
            check(irq_out_n, 0, "irq");
            host.rd(`HT_A_STAT, v);
            check(v[3], 1, "udr");
            host.wr(`HT_A_STAT, 0, r);
            host.rd(`HT_A_STAT, v);
            check(v[3], 0, "udr clr");
            wt(3);
            check(irq_out_n, 1, "irq off");
            host.wr(`HT_A_IEN, 0, r);
        end
    endtask
    task t_fill;
        begin
            host.wr(`HT_A_CFG, 0, r);
            repeat (20) host.wr(`HT_A_DATA, 1, r);
            host.rd(`HT_A_STAT, v);
            host.wr(`HT_A_CFG, 4, r);
            host.wr(`HT_A_CFG, 0, r);
            repeat (128) host.wr(`HT_A_DATA, 2, r);
            check(overflow_output, 0, "ovr");
            host.rd(`HT_A_STAT, v);
            check(v[5:0], 6'h13, "full");
            host.wr(`HT_A_DATA, 3, r);
            wt(3);
            check(overflow_output, 1, "ovr set");
            host.rd(`HT_A_STAT, v);
            check(v[5:0], 6'h14, "ovr stat");
            host.wr(`HT_A_CFG, 4, r);
            host.wr(`HT_A_CFG, 0, r);
            host.rd(`HT_A_STAT, v);
            check({overflow_output, v[5:4]}, 3'h6, "drained");
            host.wr(`HT_A_DATA, 4, r);
            wt(2);
            check(overflow_output, 0, "ovr clr");
        end
    endtask
    // writes outrun the line until the packet in flight overflows
    task t_ovr_cur;
        begin
            host.wr(`HT_A_CFG, 1, r);
            for (i = 0; i < 400 && !overflow_output; i = i + 1) host.wr(`HT_A_DATA, 8'h55, r);
            clr;
            wt(60);
            check({overflow_output, abt}, 2'h3, "ovr abt");
            host.rd(`HT_A_STAT, v);
            check(v[5:4], 2'h2, "emptied");
            check(v[2], 1, "ovr ev");
            host.wr(`HT_A_DATA, 8'h55, r);
            wt(2);
            check(overflow_output, 0, "ovr rel");
        end
    endtask
    initial begin
        {failures, compares, run, nb} = 0;
        {aresetn, bit_tick, dat5, abt, flg} = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_idle;
        t_packet;
        t_underrun;
        t_fill;
        t_ovr_cur;
        test_done;
    end
    initial begin
        #(40 * 20000);
        failures = failures + 1;
        test_done;
    end
endmodule // test_hdlct_top
